/* File: design/tfp_debounce.sv */
/*
  Synchronises and debounces the raw front-panel switches and turns
  each settled closure into a single one-cycle press event.
  Assumes raw switch levels are active high and fully asynchronous.
*/
`timescale 1ns/1ps
module tfp_debounce #(
  parameter int DEB_CYC = tfp_pkg::DEB_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Raw switch levels
  input wire logic [tfp_pkg::NSW-1:0] sw_raw,
  // Cleaned events
  tfp_sw_if.src sw
);
  import tfp_pkg::*;

  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  logic [NSW-1:0] meta_r;    // First sync stage, read only by sync_r
  logic [NSW-1:0] sync_r;    // Second sync stage
  logic [NSW-1:0] stable_r;  // Settled level
  logic [NSW-1:0] press_r;   // Event pulses
  tfp_cnt_t cnt_r [NSW];     // Settle counters, one per switch

  // Two-stage synchroniser
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= sw_raw;
      sync_r <= meta_r;
    end
  end

  // Settle counter: a level must hold unchanged for the full window,
  // so a bouncing contact restarts the count and never leaks a pulse
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stable_r <= '0;
      press_r <= '0;
      for (int i = 0; i < NSW; i++) begin
        cnt_r[i] <= '0;
      end
    end else begin
      for (int i = 0; i < NSW; i++) begin
        press_r[i] <= 1'b0;
        if (sync_r[i] == stable_r[i]) begin
          cnt_r[i] <= '0;
        end else if (cnt_r[i] == tfp_cnt_t'(DEB_CYC - 1)) begin
          cnt_r[i] <= '0;
          stable_r[i] <= sync_r[i];
          press_r[i] <= sync_r[i];
        end else begin
          cnt_r[i] <= cnt_r[i] + TMR_LAST;
        end
      end
    end
  end

  assign sw.press = press_r;

  // Never two event cycles in a row for the same switch
  AST_ONE_PULSE: assert property (@(posedge clk) disable iff (rst)
    (press_r != '0) |=> ((press_r & $past(press_r)) == '0))
    else $error("switch event longer than one cycle");
endmodule

/* File: design/tfp_panel.sv */
/*
  Front-panel controller of a tape drive: interprets operator switch
  presses, drives lamps and the message display, tracks densities.
  Assumes transport status and host motion inputs share clk.
*/
// What this block does
// - Power button toggles dc power and lamp
// - Power-up flashes lamps, shows test messages
// - Density ignored unless offline and either unloaded or at beginning
// - Density press cycles 1600/6250, shows commanded
// - Found density governs, commanded does not override
// - Test button offline only, enters service mode
// - Online button toggles online state and lamp
// - Unload only proceeds while offline
// - Unload flashes lamp, then lit with done
// - Unload during load aborts, shows message, unloads
// - Load/rewind ignored while online
// - Load press at beginning shows density five seconds
// - Power-up adopts stored default density
// - Write after beginning read uses found density
`timescale 1ns/1ps
module tfp_panel #(
  parameter int DEB_CYC = tfp_pkg::DEB_CYC,
  parameter int HOLD_CYC = tfp_pkg::HOLD_CYC,
  parameter int DONE_CYC = tfp_pkg::DONE_CYC,
  parameter int FLASH_CYC = tfp_pkg::FLASH_CYC,
  parameter int TEST_CYC = tfp_pkg::TEST_CYC,
  parameter int PHASE_CYC = tfp_pkg::PHASE_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Raw front-panel switches
  input wire logic [tfp_pkg::NSW-1:0] sw_raw,
  // Transport and host status
  input wire logic tape_loaded,
  input wire logic beginning_of_tape,
  input wire logic wrt_ring,
  input wire logic mot_done,
  input wire logic flush_done,
  input wire tfp_pkg::tfp_found_t found_kind,
  input wire logic nv_density_6250,
  input wire logic host_read,
  input wire logic host_write,
  // Power and mode
  output logic dc_power,
  output logic online,
  output logic service_mode,
  // Transport requests, one-cycle pulses
  output logic load_req,
  output logic rewind_req,
  output logic unload_req,
  output logic load_abort,
  output logic flush_req,
  // Densities
  output logic op_density_6250,
  output logic cmd_density_6250,
  output logic wr_density_6250,
  // Display and lamps
  output tfp_pkg::tfp_msg_t msg_code,
  output logic msg_6250,
  output logic lamp_power,
  output logic lamp_load,
  output logic lamp_unload,
  output logic lamp_online,
  output logic lamp_test,
  output logic lamp_density
);
  import tfp_pkg::*;

  // ---------------------------------------------------------------
  // Switch events
  // ---------------------------------------------------------------
  tfp_sw_if sw_if ();
  tfp_debounce #(.DEB_CYC(DEB_CYC)) u_deb (.clk(clk), .rst(rst), .sw_raw(sw_raw), .sw(sw_if));

  function automatic logic tfp_expired(input tfp_cnt_t t);
    return t == TMR_LAST;
  endfunction

  function automatic tfp_msg_t tfp_found_msg(input tfp_found_t f);
    if (f == found_blank) return blank_tape_msg;
    else if (f == found_unknown) return unreadable_format_msg;
    else return found_density_msg;
  endfunction

  tfp_state_t state_r;           // Control state
  tfp_cnt_t tmr_r;               // Phase and message-hold timer
  tfp_msg_t msg_r;               // Displayed message
  logic power_r, online_r, svc_r;
  logic cmd_r, op_r, disp_r, wr_r, rd_bot_r;
  logic load_r, rew_r, unl_r, abort_r, flush_r;
  logic flash_r, l_pwr_r, l_load_r, l_unl_r, l_onl_r, l_test_r, l_den_r;
  tfp_cnt_t flash_cnt_r;         // Flash divider

  logic [NSW-1:0] press;
  logic pwr_press, idle, acc_den, acc_test, acc_online, acc_unload, acc_load;
  logic found_ok, found_now, test_phase, run_ok, expired;
  assign press = sw_if.press;
  assign pwr_press = press[SW_POWER];
  // Power press outranks every other switch in the same cycle
  assign idle = (state_r == ST_IDLE) && !pwr_press;
  assign acc_den = idle && press[SW_DEN] && !online_r && (!tape_loaded || beginning_of_tape);
  assign acc_test = idle && press[SW_TEST] && !online_r;
  assign acc_online = idle && press[SW_ONLINE];
  assign acc_unload = idle && press[SW_UNLOAD] && !online_r;
  assign acc_load = idle && press[SW_LOAD] && !online_r;
  assign found_ok = (found_kind == found_1600) || (found_kind == found_6250);
  // Cycle in which a found-density result is presented
  assign found_now = !pwr_press && ((((state_r == ST_LOAD) && !press[SW_UNLOAD]) || (state_r == ST_REWIND)) && mot_done
    || acc_load && tape_loaded && beginning_of_tape);
  assign test_phase = (state_r == ST_RUN) || (state_r == ST_PASS);
  assign run_ok = state_r inside {ST_IDLE, ST_LOAD, ST_ABORT, ST_REWIND, ST_UNLOAD, ST_FLUSH};
  assign expired = tfp_expired(tmr_r);

  // ---------------------------------------------------------------
  // Main sequence: power-up, load, rewind, unload, flush
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= ST_RUN;
      tmr_r <= tfp_cnt_t'(TEST_CYC);
      msg_r <= testing_msg;
    end else begin
      if (tmr_r != '0) begin
        tmr_r <= tmr_r - TMR_LAST;
      end
      if (pwr_press) begin
        if (state_r == ST_OFF) begin
          state_r <= ST_RUN;
          tmr_r <= tfp_cnt_t'(TEST_CYC);
          msg_r <= testing_msg;
        end else begin
          state_r <= ST_OFF;
          tmr_r <= '0;
          msg_r <= msg_none;
        end
      end else begin
        case (state_r)
          ST_RUN: if (expired) begin
            state_r <= ST_PASS;
            tmr_r <= tfp_cnt_t'(PHASE_CYC);
            msg_r <= self_test_passed_msg;
          end
          ST_PASS: if (expired) begin // Lamps go dark, message stays
            state_r <= ST_DARK;
            tmr_r <= tfp_cnt_t'(PHASE_CYC);
          end
          ST_DARK: if (expired) begin
            state_r <= ST_BLANK;
            tmr_r <= tfp_cnt_t'(PHASE_CYC);
            msg_r <= msg_none;
          end
          ST_BLANK: if (expired) begin
            state_r <= ST_IDLE;
          end
          ST_IDLE: begin
            if (expired) begin // Timed message ends
              msg_r <= msg_none;
            end
            if (acc_den) begin
              msg_r <= cmd_density_msg;
              tmr_r <= tfp_cnt_t'(HOLD_CYC);
            end else if (acc_online && online_r) begin
              state_r <= ST_FLUSH;
            end else if (acc_unload) begin
              state_r <= ST_UNLOAD;
              msg_r <= unloading_msg;
              tmr_r <= '0;
            end else if (acc_load && !tape_loaded) begin
              state_r <= ST_LOAD;
              msg_r <= loading_msg;
              tmr_r <= '0;
            end else if (acc_load && beginning_of_tape) begin
              msg_r <= tfp_found_msg(found_kind);
              tmr_r <= tfp_cnt_t'(HOLD_CYC);
            end else if (acc_load) begin
              state_r <= ST_REWIND;
              msg_r <= rewinding_msg;
              tmr_r <= '0;
            end
          end
          ST_LOAD: if (press[SW_UNLOAD]) begin
            state_r <= ST_ABORT;
            msg_r <= load_aborted_msg;
            tmr_r <= tfp_cnt_t'(DONE_CYC);
          end else if (mot_done) begin
            state_r <= ST_IDLE;
            msg_r <= tfp_found_msg(found_kind);
            tmr_r <= tfp_cnt_t'(HOLD_CYC);
          end
          ST_ABORT: if (expired) begin
            state_r <= ST_UNLOAD;
            msg_r <= unloading_msg;
          end
          ST_REWIND: if (mot_done) begin
            state_r <= ST_IDLE;
            msg_r <= tfp_found_msg(found_kind);
            tmr_r <= tfp_cnt_t'(HOLD_CYC);
          end
          ST_UNLOAD: if (mot_done) begin
            state_r <= ST_IDLE;
            msg_r <= unloaded_msg;
            tmr_r <= tfp_cnt_t'(DONE_CYC);
          end
          ST_FLUSH: if (flush_done) begin
            state_r <= ST_IDLE;
          end
          ST_OFF: state_r <= ST_OFF;
          default: state_r <= ST_IDLE;
        endcase
      end
    end
  end

  // Power, online and service mode; the test switch touches no write enable
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      power_r <= 1'b1;
      online_r <= 1'b0;
      svc_r <= 1'b0;
    end else begin
      if (pwr_press) begin
        power_r <= !power_r;
      end
      if (pwr_press || state_r == ST_OFF) begin
        online_r <= 1'b0;
        svc_r <= 1'b0;
      end else begin
        if (acc_online && !online_r) begin
          online_r <= 1'b1;
        end else if (state_r == ST_FLUSH && flush_done) begin
          online_r <= 1'b0;
        end
        if (acc_test) begin
          svc_r <= !svc_r;
        end
      end
    end
  end

  // Transport request pulses
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      load_r <= 1'b0;
      rew_r <= 1'b0;
      unl_r <= 1'b0;
      abort_r <= 1'b0;
      flush_r <= 1'b0;
    end else begin
      load_r <= acc_load && !tape_loaded;
      rew_r <= acc_load && tape_loaded && !beginning_of_tape;
      unl_r <= acc_unload || (state_r == ST_ABORT && expired && !pwr_press);
      abort_r <= state_r == ST_LOAD && press[SW_UNLOAD] && !pwr_press;
      flush_r <= acc_online && online_r;
    end
  end

  // Densities: commanded, operating and displayed density
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cmd_r <= 1'b0;
      op_r <= 1'b0;
      disp_r <= 1'b0;
    end else if (state_r == ST_RUN) begin
      cmd_r <= nv_density_6250;
      op_r <= nv_density_6250;
      disp_r <= nv_density_6250;
    end else if (acc_den) begin
      cmd_r <= !cmd_r;
      disp_r <= !cmd_r;
      if (!tape_loaded) begin
        op_r <= !cmd_r;
      end
    end else if (found_now && found_ok) begin
      op_r <= found_kind == found_6250;
      disp_r <= found_kind == found_6250;
    end
  end

  // A write straight after a read at the beginning keeps the found density
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_bot_r <= 1'b0;
      wr_r <= 1'b0;
    end else begin
      if (host_write) begin
        wr_r <= (rd_bot_r && found_ok) ? (found_kind == found_6250) : cmd_r;
        rd_bot_r <= 1'b0;
      end else if (host_read) begin
        rd_bot_r <= beginning_of_tape;
      end else if (rew_r || load_r) begin
        rd_bot_r <= 1'b0;
      end
    end
  end

  // Flash divider, one toggle per half period
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flash_cnt_r <= '0;
      flash_r <= 1'b0;
    end else if (flash_cnt_r == tfp_cnt_t'(FLASH_CYC - 1)) begin
      flash_cnt_r <= '0;
      flash_r <= !flash_r;
    end else begin
      flash_cnt_r <= flash_cnt_r + TMR_LAST;
    end
  end

  // Lamps; all flash together during self-test
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      l_pwr_r <= 1'b0;
      l_load_r <= 1'b0;
      l_unl_r <= 1'b0;
      l_onl_r <= 1'b0;
      l_test_r <= 1'b0;
      l_den_r <= 1'b0;
    end else begin
      l_pwr_r <= test_phase ? flash_r : run_ok;
      l_load_r <= test_phase ? flash_r : (state_r inside {ST_LOAD, ST_REWIND}) && flash_r;
      l_unl_r <= test_phase ? flash_r : (state_r == ST_UNLOAD) ? flash_r : run_ok && !tape_loaded;
      l_onl_r <= test_phase ? flash_r : run_ok && online_r;
      l_test_r <= test_phase ? flash_r : run_ok && tape_loaded && wrt_ring;
      l_den_r <= test_phase && flash_r;
    end
  end

  assign dc_power = power_r;
  assign online = online_r;
  assign service_mode = svc_r;
  assign load_req = load_r;
  assign rewind_req = rew_r;
  assign unload_req = unl_r;
  assign load_abort = abort_r;
  assign flush_req = flush_r;
  assign op_density_6250 = op_r;
  assign cmd_density_6250 = cmd_r;
  assign wr_density_6250 = wr_r;
  assign msg_code = msg_r;
  assign msg_6250 = disp_r;
  assign lamp_power = l_pwr_r;
  assign lamp_load = l_load_r;
  assign lamp_unload = l_unl_r;
  assign lamp_online = l_onl_r;
  assign lamp_test = l_test_r;
  assign lamp_density = l_den_r;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence seq_pass;
    state_r == ST_RUN ##1 state_r == ST_PASS;
  endsequence
  sequence seq_abort;
    state_r == ST_LOAD && press[SW_UNLOAD] && !pwr_press;
  endsequence

  AST_PWR_TOGGLE: assert property (pwr_press |=> dc_power != $past(dc_power))
    else $error("power press did not toggle dc power");
  // Lamps keep flashing while ST_PASS shows the pass message, so darkness is checked one phase later
  AST_TEST_PASS: assert property (seq_pass |-> msg_r == self_test_passed_msg)
    else $error("self-test pass sequence wrong");
  AST_LAMPS_DARK: assert property ((state_r == ST_DARK) |=> !l_den_r && !l_load_r && !l_unl_r)
    else $error("lamps lit in dark phase");
  AST_DEN_IGNORED: assert property ((state_r == ST_IDLE && press[SW_DEN]
    && (online_r || (tape_loaded && !beginning_of_tape))) |=> $stable(cmd_r))
    else $error("density press accepted in wrong state");
  AST_DEN_CYCLE: assert property (acc_den |=> cmd_r != $past(cmd_r) && msg_r == cmd_density_msg)
    else $error("density press did not cycle density");
  AST_SVC_OFFLINE: assert property ($rose(svc_r) |-> !$past(online_r))
    else $error("service mode entered while online");
  AST_ONLINE_LAMP: assert property ((acc_online && !online_r) |=> online_r ##1 lamp_online)
    else $error("online press did not light lamp");
  AST_FLUSH_FIRST: assert property ((state_r == ST_FLUSH && !flush_done && !pwr_press) |=> online_r)
    else $error("went offline before flush finished");
  AST_UNLOAD_OFFLINE: assert property (unl_r |-> !online_r)
    else $error("unload requested while online");
  AST_LOAD_ABORT: assert property (seq_abort |=> abort_r && msg_r == load_aborted_msg)
    else $error("unload during load not aborted");
  AST_LOAD_ONLINE: assert property ((load_r || rew_r) |-> !online_r)
    else $error("load or rewind while online");
endmodule

/* File: design/tfp_pkg.sv */
/*
  Shared constants and types for the front-panel control block of a
  reel-to-reel tape drive: switch indices, timing, messages, states.
  Assumes a single 20 MHz clock for every user of this package.
*/
package tfp_pkg;
  // ---------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ = 20_000_000;
  localparam int MS_DIV = 1000;
  localparam int DEB_MS = 10;          // Switch bounce settle time
  localparam int HOLD_S = 5;           // Density message hold
  localparam int DONE_S = 2;           // Short completion messages
  localparam int FLASH_MS = 250;       // Lamp flash half period
  localparam int TEST_MS = 2000;       // Self-test running phase
  localparam int PHASE_MS = 500;       // Each later power-up phase
  localparam int DEB_CYC = CLK_HZ / MS_DIV * DEB_MS;
  localparam int HOLD_CYC = CLK_HZ * HOLD_S;
  localparam int DONE_CYC = CLK_HZ * DONE_S;
  localparam int FLASH_CYC = CLK_HZ / MS_DIV * FLASH_MS;
  localparam int TEST_CYC = CLK_HZ / MS_DIV * TEST_MS;
  localparam int PHASE_CYC = CLK_HZ / MS_DIV * PHASE_MS;
  // Counter wide enough for the five-second hold
  localparam int CNT_W = 27;
  typedef logic [CNT_W-1:0] tfp_cnt_t;
  localparam tfp_cnt_t TMR_LAST = 27'h0000001;
  // ---------------------------------------------------------------
  // Switches
  // ---------------------------------------------------------------
  localparam int NSW = 6;
  localparam int SW_POWER = 0;
  localparam int SW_DEN = 1;
  localparam int SW_TEST = 2;
  localparam int SW_ONLINE = 3;
  localparam int SW_UNLOAD = 4;
  localparam int SW_LOAD = 5;
  // ---------------------------------------------------------------
  // Messages, identified tape format, control states
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    msg_none = 4'h0, testing_msg = 4'h1, self_test_passed_msg = 4'h2,
    cmd_density_msg = 4'h3, loading_msg = 4'h4, found_density_msg = 4'h5,
    blank_tape_msg = 4'h6, unreadable_format_msg = 4'h7, unloading_msg = 4'h8,
    unloaded_msg = 4'h9, load_aborted_msg = 4'hA, rewinding_msg = 4'hB
  } tfp_msg_t;
  typedef enum logic [1:0] {
    found_1600 = 2'h0, found_6250 = 2'h1, found_blank = 2'h2, found_unknown = 2'h3
  } tfp_found_t;
  typedef enum logic [10:0] {
    ST_OFF = 11'h001, ST_RUN = 11'h002, ST_PASS = 11'h004, ST_DARK = 11'h008,
    ST_BLANK = 11'h010, ST_IDLE = 11'h020, ST_LOAD = 11'h040, ST_ABORT = 11'h080,
    ST_REWIND = 11'h100, ST_UNLOAD = 11'h200, ST_FLUSH = 11'h400
  } tfp_state_t;
endpackage

/* File: design/tfp_sw_if.sv */
/*
  Carrier for the cleaned switch events between the debouncer and
  the panel controller. Both ends share one clock.
*/
`timescale 1ns/1ps
interface tfp_sw_if;
  logic [tfp_pkg::NSW-1:0] press; // One-cycle press events
  modport src (output press);
  modport dst (input press);
endinterface

/* File: testbench/tb.sv */
/*
  Self-checking bench for the tape front-panel controller.
  Assumes the operator model drives switches and transport status.
*/
`timescale 1ns/1ps
module tb;
  import tfp_pkg::*;
  logic clk = 1'b0;
  logic rst, wrt_ring, nv_density_6250, host_read, host_write;
  tfp_found_t found_kind;
  logic [NSW-1:0] sw_raw;
  logic tape_loaded, beginning_of_tape, mot_done, flush_done;
  logic dc_power, online, service_mode, load_req, rewind_req, unload_req, load_abort, flush_req;
  logic op_density_6250, cmd_density_6250, wr_density_6250, msg_6250;
  logic lamp_power, lamp_load, lamp_unload, lamp_online, lamp_test, lamp_density;
  tfp_msg_t msg_code;
  int err_total = 0;
  int n_tests = 0;
  int n_ld = 0, n_rw = 0, n_ul = 0, n_ab = 0, n_fl = 0; // Pulse tallies
  always #25 clk = ~clk; // 20 MHz
  tfp_panel #(.DEB_CYC(4), .HOLD_CYC(50), .DONE_CYC(20), .FLASH_CYC(4), .TEST_CYC(20), .PHASE_CYC(10))
  u_tfp_panel (.clk(clk), .rst(rst), .sw_raw(sw_raw), .tape_loaded(tape_loaded),
    .beginning_of_tape(beginning_of_tape), .wrt_ring(wrt_ring), .mot_done(mot_done),
    .flush_done(flush_done), .found_kind(found_kind), .nv_density_6250(nv_density_6250),
    .host_read(host_read), .host_write(host_write), .dc_power(dc_power), .online(online),
    .service_mode(service_mode), .load_req(load_req), .rewind_req(rewind_req),
    .unload_req(unload_req), .load_abort(load_abort), .flush_req(flush_req),
    .op_density_6250(op_density_6250), .cmd_density_6250(cmd_density_6250),
    .wr_density_6250(wr_density_6250), .msg_code(msg_code), .msg_6250(msg_6250),
    .lamp_power(lamp_power), .lamp_load(lamp_load), .lamp_unload(lamp_unload),
    .lamp_online(lamp_online), .lamp_test(lamp_test), .lamp_density(lamp_density));
  tfp_operator u_op (.clk(clk), .sw_raw(sw_raw), .tape_loaded(tape_loaded),
    .beginning_of_tape(beginning_of_tape), .mot_done(mot_done), .flush_done(flush_done),
    .load_req(load_req), .rewind_req(rewind_req), .unload_req(unload_req),
    .load_abort(load_abort), .flush_req(flush_req));
  // ------------------------------------------------------------
  // Pulse tallies: one-cycle requests are missed by level checks
  // ------------------------------------------------------------
  always @(posedge clk) begin
    n_ld <= n_ld + int'(load_req === 1'b1);
    n_rw <= n_rw + int'(rewind_req === 1'b1);
    n_ul <= n_ul + int'(unload_req === 1'b1);
    n_ab <= n_ab + int'(load_abort === 1'b1);
    n_fl <= n_fl + int'(flush_req === 1'b1);
  end
  // ------------------------------------------------------------
  // Check helpers
  // ------------------------------------------------------------
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t got %0h expected %0h", $time, got, exp);
    end
  endtask
  // Bounded wait: 0 message, 1 online, 2 unload lamp
  task automatic wt(input int s, input logic [3:0] v);
    for (int k = 0; k < 400; k++) begin
      @(posedge clk) #1;
      if ((s == 0 ? msg_code : s == 1 ? {3'h0, online} : {3'h0, lamp_unload}) === v) begin
        n_tests++;
        return;
      end
    end
    err_total++;
    $display("BAD %0t wait %0d ran out", $time, s);
    finish_test();
  endtask
  // Host motion pulse, result settles one edge later
  task automatic hp(input logic w);
    @(posedge clk) #1 host_write = w;
    host_read = !w;
    @(posedge clk) #1 host_write = 1'b0;
    host_read = 1'b0;
    @(posedge clk) #1;
  endtask
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    rst = 1'b1;
    wrt_ring = 1'b0;
    nv_density_6250 = 1'b0;
    host_read = 1'b0;
    host_write = 1'b0;
    found_kind = found_6250;
    repeat (16) @(posedge clk);
    chk(msg_code, testing_msg);
    #1 rst = 1'b0;
    wt(0, self_test_passed_msg);
    wt(0, msg_none);
    chk({lamp_density, lamp_load}, 2'h0);
    wt(2, 4'h1);
    chk(lamp_power, 1'b1);
    chk(op_density_6250, 1'b0);
    u_op.press(SW_DEN);
    chk({msg_code, 3'h0, msg_6250}, {cmd_density_msg, 4'h1});
    chk(cmd_density_6250, 1'b1);
    u_op.press(SW_DEN);
    chk(cmd_density_6250, 1'b0);
    u_op.press(SW_ONLINE);
    chk({online, lamp_online}, 2'h3);
    u_op.press(SW_DEN);
    chk(cmd_density_6250, 1'b0);
    u_op.press(SW_LOAD);
    u_op.press(SW_TEST);
    u_op.press(SW_UNLOAD);
    chk({8'(n_ld), 8'(n_ul), service_mode}, 17'h0);
    u_op.press(SW_ONLINE);
    chk({8'(n_fl), online}, 9'h003);
    wt(1, 4'h0);
    @(posedge clk) #1 chk(lamp_online, 1'b0);
    u_op.press(SW_TEST);
    chk(service_mode, 1'b1);
    u_op.press(SW_TEST);
    wrt_ring = 1'b1;
    u_op.press(SW_LOAD);
    chk({8'(n_ld), msg_code}, {8'h01, loading_msg});
    wt(0, found_density_msg);
    chk({msg_6250, op_density_6250, lamp_test}, 3'h7);
    hp(1'b0);
    hp(1'b1);
    chk(wr_density_6250, 1'b1);
    @(posedge clk) #1 u_op.beginning_of_tape = 1'b0;
    u_op.press(SW_DEN);
    chk(cmd_density_6250, 1'b0);
    found_kind = found_1600;
    u_op.press(SW_LOAD);
    chk(8'(n_rw), 8'h01);
    wt(0, found_density_msg);
    chk({msg_6250, op_density_6250}, 2'h0);
    hp(1'b1);
    chk(wr_density_6250, 1'b0);
    u_op.press(SW_DEN);
    chk({cmd_density_6250, op_density_6250, msg_code}, {2'h2, cmd_density_msg});
    u_op.press(SW_LOAD);
    chk({8'(n_rw), msg_code, msg_6250}, {8'h01, found_density_msg, 1'b0});
    u_op.press(SW_UNLOAD);
    chk({8'(n_ul), msg_code}, {8'h01, unloading_msg});
    wt(0, unloaded_msg);
    @(posedge clk) #1 chk(lamp_unload, 1'b1);
    u_op.mot_dly = 200;
    u_op.press(SW_LOAD);
    u_op.press(SW_UNLOAD);
    chk({8'(n_ab), msg_code}, {8'h01, load_aborted_msg});
    wt(0, unloading_msg);
    @(posedge clk) #1 chk(8'(n_ul), 8'h02);
    wt(0, unloaded_msg);
    u_op.press(SW_POWER);
    chk({dc_power, lamp_power}, 2'h0);
    // Mid-run reset with the other stored default density
    nv_density_6250 = 1'b1;
    rst = 1'b1;
    @(posedge clk) #1 rst = 1'b0;
    wt(0, self_test_passed_msg);
    chk({dc_power, cmd_density_6250, op_density_6250}, 3'h7);
    finish_test();
  end
endmodule

/* File: testbench/tfp_operator.sv */
/*
  Far side of the front panel: an operator who presses switches with
  one contact bounce, plus a plain transport that answers motions.
  Assumes the panel's request outputs are one-cycle pulses on clk.
*/
`timescale 1ns/1ps
module tfp_operator #(
  parameter int DEB = 4
) (
  // Clock
  input wire logic clk,
  // Switches and transport status
  output logic [tfp_pkg::NSW-1:0] sw_raw,
  output logic tape_loaded,
  output logic beginning_of_tape,
  output logic mot_done,
  output logic flush_done,
  // Requests from the panel
  input wire logic load_req,
  input wire logic rewind_req,
  input wire logic unload_req,
  input wire logic load_abort,
  input wire logic flush_req
);
  int mot_dly = 30; // Motion time, raised to catch a load in flight
  int mcnt = 0;
  int fcnt = 0;
  logic unl = 1'b0;
  initial begin
    sw_raw = '0;
    tape_loaded = 1'b0;
    beginning_of_tape = 1'b0;
    mot_done = 1'b0;
    flush_done = 1'b0;
  end
  // ------------------------------------------------------------
  // Press: a short glitch first, so one press must stay one event
  // ------------------------------------------------------------
  task automatic press(input int i);
    @(posedge clk) #1 sw_raw[i] = 1'b1;
    @(posedge clk) #1 sw_raw[i] = 1'b0;
    @(posedge clk) #1 sw_raw[i] = 1'b1;
    repeat (DEB + 6) @(posedge clk);
    #1 sw_raw[i] = 1'b0;
    repeat (DEB + 6) @(posedge clk);
    #1;
  endtask
  // ------------------------------------------------------------
  // Transport: status settles one cycle before the done pulse
  // ------------------------------------------------------------
  always @(posedge clk) begin
    #1 mot_done = 1'b0;
    flush_done = 1'b0;
    if (load_req || rewind_req || unload_req) begin
      mcnt = mot_dly;
      unl = unload_req;
    end
    if (load_abort) mcnt = 0; // Abort cancels the load in flight
    if (mcnt == 2) begin
      tape_loaded = !unl;
      beginning_of_tape = !unl;
    end
    if (mcnt == 1) mot_done = 1'b1;
    if (mcnt > 0) mcnt--;
    if (flush_req) fcnt = 40; // Slow flush keeps online visible
    if (fcnt == 1) flush_done = 1'b1;
    if (fcnt > 0) fcnt--;
  end
endmodule
